//--- triple_timer_counter_unit.sv
// three 16-bit timer/counters behind an AXI4-Lite slave
// Functional notes
// [RQ1] three independent 16-bit up-counters, each readable and writable by software
// [RQ2] timers 0 and 1 steered by shared control (88H) and mode (89H) registers
// [RQ3] timers 0 and 1 each pick one of four modes independently; split mode (11) is not built here and only holds the count
// [RQ4] external-clock timers 0/1 keep counting pin edges while oscillator is stopped
// [RQ5] timer 0/1 carry during power-down wakes the cpu
// [RQ6] timer 2 steered by its own control register at 0C8H, three modes; capture and reload not built here, the counter only wraps
// [RQ7] timer 2 never counts while the oscillator is stopped
// [RQ8] timer 2 clock source 0 counts internal clock, 1 counts its pin
// [RQ9] timer 2 run bit 1 starts counting, 0 halts it
// [RQ10] trigger enable 0 blocks trigger pin, 1 lets it act
// [RQ11] software clears the timer 2 event flag; hardware never does
// [RQ12] timer 2 overflow sets the timer 2 carry flag
// [RQ13] timer 2 carry flag requests interrupt and stays until software clears
// [RQ14] enabled falling trigger pin sets timer 2 event flag, requesting interrupt
// [RQ15] tx/rx select bits pick timer 2 overflow instead of timer 1 as baud
// [RQ16] in baud generator use timer 2 overflow leaves carry flag alone
// [RQ17] gate set: count needs run and irq pin high; clear: run alone
// [RQ18] mode 00 13-bit, 01 16-bit, 10 8-bit with 8-bit auto-reload
// [RQ19] run bits 4 and 6 of control register: 0 stops, 1 enables
`timescale 1ns/1ps
`default_nettype none
module triple_timer_counter_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // axi4-lite write channels
  input wire logic [timer_unit_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [timer_unit_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [timer_unit_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [timer_unit_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external pins
  input wire timer_unit_pkg::pins_t pins,
  // system side
  output logic irq,
  output logic cpuWake,
  output logic oscillatorStopped,
  output logic serialTxBaudTick,
  output logic serialRxBaudTick
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  wire logic [timer_unit_pkg::PIN_W-1:0] pinLevel;
  wire logic [timer_unit_pkg::PIN_W-1:0] pinFall;
  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [timer_unit_pkg::ADDR_W-1:0] awAddr_q;
  logic [timer_unit_pkg::DATA_W-1:0] wData_q, rData_q, rdMux;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic rdHit, wrHit, doWrite;
  logic [7:0] wIdx, rIdx;
  logic [7:0] t01Ctl_q, t01Mode_q;
  timer_unit_pkg::timer2Control_t t2Ctl_q;
  logic [timer_unit_pkg::CNT_W-1:0] t2Cnt_q;
  wire logic [timer_unit_pkg::CNT_W-1:0] cnt01 [2];
  wire logic [1:0] carry01;
  logic [timer_unit_pkg::IRQ_W-1:0] irqStat_q, irqMask_q;
  logic [timer_unit_pkg::PWR_W-1:0] power_q;
  logic [3:0] presc_q;
  logic half_q, oscRun, intTick, halfTick, wake_q, txTick_q, rxTick_q;
  logic t2Tick, t2Ovf, t2Baud, t2Event;

  // one synchroniser per pin
  for (genvar p = 0; p < timer_unit_pkg::PIN_W; p++)
  begin : g_pin
    pin_synchronizer u_sync (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .pinAsync(pins[p]),
      .level(pinLevel[p]),
      .fall(pinFall[p])
    );
  end

  // bus handshake: address and data are taken in either order
  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign wIdx = awAddr_q[timer_unit_pkg::IDX_MSB:timer_unit_pkg::IDX_LSB];
  assign rIdx = s_axi_araddr[timer_unit_pkg::IDX_MSB:timer_unit_pkg::IDX_LSB];
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rresp_q;

  // index decode; upper address bits must be zero
  function automatic logic mapped(input logic [timer_unit_pkg::ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[timer_unit_pkg::IDX_MSB:timer_unit_pkg::IDX_LSB];
    mapped = (a[timer_unit_pkg::ADDR_W-1:timer_unit_pkg::IDX_MSB+1] == '0) &&
      (i == timer_unit_pkg::IDX_T01CTL || i == timer_unit_pkg::IDX_T01MODE ||
       i == timer_unit_pkg::IDX_TIMER2CTL || i == timer_unit_pkg::IDX_TIMER0CNT ||
       i == timer_unit_pkg::IDX_TIMER1CNT || i == timer_unit_pkg::IDX_TIMER2CNT ||
       i == timer_unit_pkg::IDX_IRQSTAT || i == timer_unit_pkg::IDX_IRQMASK ||
       i == timer_unit_pkg::IDX_POWER);
  endfunction
  assign wrHit = doWrite && mapped(awAddr_q);
  assign rdHit = mapped(s_axi_araddr);

  // write path holding registers and response
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bvalid_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bresp_q <= timer_unit_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrHit ? timer_unit_pkg::RESP_OKAY : timer_unit_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // read mux; unmapped words read zero with an error response
  always_comb
  begin
    rdMux = '0;
    case (rIdx)
      timer_unit_pkg::IDX_T01CTL: rdMux[timer_unit_pkg::LOW_MSB:0] = t01Ctl_q;
      timer_unit_pkg::IDX_T01MODE: rdMux[timer_unit_pkg::LOW_MSB:0] = t01Mode_q;
      timer_unit_pkg::IDX_TIMER2CTL: rdMux[timer_unit_pkg::LOW_MSB:0] = t2Ctl_q;
      timer_unit_pkg::IDX_TIMER0CNT: rdMux[timer_unit_pkg::HIGH_MSB:0] = cnt01[0];
      timer_unit_pkg::IDX_TIMER1CNT: rdMux[timer_unit_pkg::HIGH_MSB:0] = cnt01[1];
      timer_unit_pkg::IDX_TIMER2CNT: rdMux[timer_unit_pkg::HIGH_MSB:0] = t2Cnt_q;
      timer_unit_pkg::IDX_IRQSTAT: rdMux[timer_unit_pkg::IRQ_W-1:0] = irqStat_q;
      timer_unit_pkg::IDX_IRQMASK: rdMux[timer_unit_pkg::IRQ_W-1:0] = irqMask_q;
      timer_unit_pkg::IDX_POWER: rdMux[timer_unit_pkg::PWR_W-1:0] = power_q;
      default: rdMux = '0;
    endcase
    if (!rdHit)
      rdMux = '0;
  end

  // read data registered, so reads have no side effects
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid_q <= 1'b0;
      rData_q <= '0;
      rresp_q <= timer_unit_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rData_q <= rdMux;
      rresp_q <= rdHit ? timer_unit_pkg::RESP_OKAY : timer_unit_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // oscillator model: stopped in either power-down mode
  assign oscRun = ~|power_q;
  assign oscillatorStopped = ~oscRun;
  assign intTick = oscRun && presc_q == timer_unit_pkg::PRESCALE_LAST;
  assign halfTick = oscRun && half_q;

  // divide-by-twelve and divide-by-two enables, frozen with the oscillator
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      presc_q <= '0;
      half_q <= 1'b0;
    end
    else if (oscRun)
    begin
      presc_q <= intTick ? 4'h0 : presc_q + 4'h1;
      half_q <= ~half_q;
    end
  end

  // power-down entry by software, exit on a timer 0/1 carry
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      power_q <= '0;
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= 1'b0;
      if (wrHit && wIdx == timer_unit_pkg::IDX_POWER && wStrb_q[0])
        power_q <= wData_q[timer_unit_pkg::PWR_W-1:0];
      if (!oscRun && |carry01)
      begin
        power_q <= '0; // [RQ5]
        wake_q <= 1'b1;
      end
    end
  end
  assign cpuWake = wake_q;

  // timers 0 and 1: identical slices of the shared registers
  for (genvar i = 0; i < 2; i++)
  begin : g_t01
    timer_unit_pkg::tmrModeHalf_t md;
    logic [timer_unit_pkg::CNT_W-1:0] cnt_q, nxt;
    logic run, tick, cry;
    logic [7:0] cntIdx;
    assign md = timer_unit_pkg::tmrModeHalf_t'(t01Mode_q[i*timer_unit_pkg::MODE_HALF_W +:
      timer_unit_pkg::MODE_HALF_W]); // [RQ2] [RQ3]
    assign run = t01Ctl_q[timer_unit_pkg::T01_RUN0 + i*timer_unit_pkg::T01_STRIDE]; // [RQ19]
    // pin edges count without the oscillator, internal ticks do not
    assign tick = run && (!md.gate || pinLevel[timer_unit_pkg::PIN_IRQ0 + i]) && // [RQ17]
      (md.extClock ? pinFall[i] : intTick); // [RQ4]
    assign cntIdx = i ? timer_unit_pkg::IDX_TIMER1CNT : timer_unit_pkg::IDX_TIMER0CNT;
    assign cnt01[i] = cnt_q;
    assign carry01[i] = cry;

    // counter structure by mode; split mode holds its count
    always_comb
    begin
      nxt = cnt_q;
      cry = 1'b0;
      if (tick)
      begin
        case (md.mode)
          timer_unit_pkg::MODE_13BIT:
          begin
            nxt[timer_unit_pkg::LOW5_MSB:0] = cnt_q[timer_unit_pkg::LOW5_MSB:0] + 5'h01; // [RQ18]
            if (&cnt_q[timer_unit_pkg::LOW5_MSB:0])
            begin
              nxt[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB] =
                cnt_q[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB] + 8'h01;
              cry = &cnt_q[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB];
            end
          end
          timer_unit_pkg::MODE_16BIT:
          begin
            nxt = cnt_q + 16'h0001; // [RQ18]
            cry = &cnt_q;
          end
          timer_unit_pkg::MODE_RELOAD8:
          begin
            cry = &cnt_q[timer_unit_pkg::LOW_MSB:0];
            nxt[timer_unit_pkg::LOW_MSB:0] = cry ? // [RQ18]
              cnt_q[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB] :
              cnt_q[timer_unit_pkg::LOW_MSB:0] + 8'h01;
          end
          default: nxt = cnt_q;
        endcase
      end
    end

    // software write of a byte lane wins over counting
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
        cnt_q <= timer_unit_pkg::CNT_RST;
      else
      begin
        cnt_q <= nxt; // [RQ1]
        if (wrHit && wIdx == cntIdx && wStrb_q[0])
          cnt_q[timer_unit_pkg::LOW_MSB:0] <= wData_q[timer_unit_pkg::LOW_MSB:0];
        if (wrHit && wIdx == cntIdx && wStrb_q[1])
          cnt_q[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB] <=
            wData_q[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB];
      end
    end

    AST_GATE_BLOCKS: assert property ((run && md.gate && !pinLevel[timer_unit_pkg::PIN_IRQ0 + i])
      |-> !tick) else $error("gated timer counted with irq pin low"); // [RQ17]
    AST_RELOAD8: assert property ((md.mode == timer_unit_pkg::MODE_RELOAD8 && tick &&
      &cnt_q[timer_unit_pkg::LOW_MSB:0] && !(wrHit && wIdx == cntIdx)) |=>
      cnt_q[timer_unit_pkg::LOW_MSB:0] == $past(cnt_q[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB]))
      else $error("8-bit reload did not preset low byte"); // [RQ18]
  end

  // shared control and mode registers; hardware carry set beats a clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t01Ctl_q <= timer_unit_pkg::REG8_RST;
      t01Mode_q <= timer_unit_pkg::REG8_RST;
    end
    else
    begin
      if (wrHit && wIdx == timer_unit_pkg::IDX_T01CTL && wStrb_q[0])
        t01Ctl_q <= wData_q[timer_unit_pkg::LOW_MSB:0]; // [RQ2]
      if (wrHit && wIdx == timer_unit_pkg::IDX_T01MODE && wStrb_q[0])
        t01Mode_q <= wData_q[timer_unit_pkg::LOW_MSB:0]; // [RQ3]
      for (int k = 0; k < 2; k++)
        if (carry01[k])
          t01Ctl_q[timer_unit_pkg::T01_FLAG0 + k*timer_unit_pkg::T01_STRIDE] <= 1'b1;
    end
  end

  // timer 2 clocking: pin falls when clock source is set, else osc/2 as baud generator, osc/12 otherwise
  assign t2Baud = t2Ctl_q.txClockSel || t2Ctl_q.rxClockSel;
  assign t2Tick = oscRun && t2Ctl_q.run && // [RQ7] [RQ9]
    (t2Ctl_q.clockSource ? pinFall[timer_unit_pkg::PIN_TIMER2CNT] : // [RQ8]
    (t2Baud ? halfTick : intTick));
  assign t2Ovf = t2Tick && &t2Cnt_q;
  assign t2Event = t2Ctl_q.triggerEnable && pinFall[timer_unit_pkg::PIN_TRIGGER]; // [RQ10]

  // timer 2 counter; capture and reload datapaths not built, it wraps
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      t2Cnt_q <= timer_unit_pkg::CNT_RST;
    else
    begin
      if (t2Tick)
        t2Cnt_q <= t2Cnt_q + 16'h0001; // [RQ1]
      if (wrHit && wIdx == timer_unit_pkg::IDX_TIMER2CNT && wStrb_q[0])
        t2Cnt_q[timer_unit_pkg::LOW_MSB:0] <= wData_q[timer_unit_pkg::LOW_MSB:0];
      if (wrHit && wIdx == timer_unit_pkg::IDX_TIMER2CNT && wStrb_q[1])
        t2Cnt_q[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB] <=
          wData_q[timer_unit_pkg::HIGH_MSB:timer_unit_pkg::HIGH_LSB];
    end
  end

  // timer 2 control; flags only ever cleared by a software write
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      t2Ctl_q <= timer_unit_pkg::REG8_RST;
    else
    begin
      if (wrHit && wIdx == timer_unit_pkg::IDX_TIMER2CTL && wStrb_q[0])
        t2Ctl_q <= wData_q[timer_unit_pkg::LOW_MSB:0]; // [RQ6] [RQ11]
      if (t2Ovf && !t2Baud)
        t2Ctl_q.carryFlag <= 1'b1; // [RQ12] [RQ16]
      if (t2Event)
        t2Ctl_q.eventFlag <= 1'b1; // [RQ14]
    end
  end

  // baud ticks for the serial port, registered
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txTick_q <= 1'b0;
      rxTick_q <= 1'b0;
    end
    else
    begin
      txTick_q <= t2Ctl_q.txClockSel ? t2Ovf : carry01[1]; // [RQ15]
      rxTick_q <= t2Ctl_q.rxClockSel ? t2Ovf : carry01[1]; // [RQ15]
    end
  end
  assign serialTxBaudTick = txTick_q;
  assign serialRxBaudTick = rxTick_q;

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStat_q <= '0;
      irqMask_q <= '0;
    end
    else
    begin
      if (wrHit && wIdx == timer_unit_pkg::IDX_IRQSTAT && wStrb_q[0])
        irqStat_q <= irqStat_q & ~wData_q[timer_unit_pkg::IRQ_W-1:0];
      if (wrHit && wIdx == timer_unit_pkg::IDX_IRQMASK && wStrb_q[0])
        irqMask_q <= wData_q[timer_unit_pkg::IRQ_W-1:0];
      if (carry01[0])
        irqStat_q[timer_unit_pkg::IRQ_TIMER0] <= 1'b1;
      if (carry01[1])
        irqStat_q[timer_unit_pkg::IRQ_TIMER1] <= 1'b1;
      if (t2Ovf && !t2Baud)
        irqStat_q[timer_unit_pkg::IRQ_T2CARRY] <= 1'b1; // [RQ13]
      if (t2Event)
        irqStat_q[timer_unit_pkg::IRQ_T2EVENT] <= 1'b1; // [RQ14]
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  // checks on bus, timer 2 and power-down wake behaviour
  sequence seqWriteDone;
    awHeld_q && wHeld_q && !bvalid_q;
  endsequence
  sequence seqT2CtlUntouched;
    !(wrHit && wIdx == timer_unit_pkg::IDX_TIMER2CTL);
  endsequence
  sequence seqT2CntUntouched;
    !(wrHit && wIdx == timer_unit_pkg::IDX_TIMER2CNT);
  endsequence

  AST_WRITE_RESP: assert property (seqWriteDone |=> s_axi_bvalid)
    else $error("no write response after both channels taken");
  AST_T2_OSC_STOP: assert property ((!oscRun ##0 seqT2CntUntouched) |=> $stable(t2Cnt_q))
    else $error("timer 2 counted with oscillator stopped"); // [RQ7]
  AST_T2_HALT: assert property ((!t2Ctl_q.run ##0 seqT2CntUntouched) |=> $stable(t2Cnt_q))
    else $error("timer 2 counted while halted"); // [RQ9]
  AST_T2_CARRY_SET: assert property ((t2Ovf && !t2Baud ##0 seqT2CntUntouched) |=> t2Ctl_q.carryFlag && t2Cnt_q == '0)
    else $error("timer 2 overflow left carry flag clear"); // [RQ12]
  AST_T2_CARRY_HOLD: assert property ((t2Ctl_q.carryFlag ##0 seqT2CtlUntouched) |=> t2Ctl_q.carryFlag)
    else $error("timer 2 carry flag dropped without software"); // [RQ13]
  AST_T2_BAUD_NOFLAG: assert property ((t2Ovf && t2Baud && !t2Ctl_q.carryFlag ##0 seqT2CtlUntouched)
    |=> !t2Ctl_q.carryFlag) else $error("baud overflow set carry flag"); // [RQ16]
  AST_TRIG_BLOCKED: assert property ((!t2Ctl_q.triggerEnable && !t2Ctl_q.eventFlag ##0 seqT2CtlUntouched)
    |=> !t2Ctl_q.eventFlag) else $error("blocked trigger set event flag"); // [RQ10]
  AST_TRIG_EVENT: assert property (t2Event |=> t2Ctl_q.eventFlag && irqStat_q[timer_unit_pkg::IRQ_T2EVENT])
    else $error("enabled trigger fall lost"); // [RQ14]
  AST_WAKE: assert property ((!oscRun && |carry01) |=> oscRun && cpuWake ##1 !cpuWake)
    else $error("carry in power-down did not wake"); // [RQ5]
  AST_TX_BAUD: assert property (t2Ctl_q.txClockSel && t2Ovf |=> serialTxBaudTick)
    else $error("tx baud tick missing on timer 2 overflow"); // [RQ15]
endmodule
`default_nettype wire

//--- timer_unit_pkg.sv
// shared constants and types of the triple timer/counter unit
package timer_unit_pkg;
  // internal count clock is the oscillator divided by twelve
  localparam int unsigned PRESCALE = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE - 1);
  // bus geometry; byte address is four times the register index
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int CNT_W = 16;
  localparam int REG8_W = 8;
  localparam logic [7:0] IDX_T01CTL = 8'h88;
  localparam logic [7:0] IDX_T01MODE = 8'h89;
  localparam logic [7:0] IDX_TIMER2CTL = 8'hc8;
  localparam logic [7:0] IDX_TIMER0CNT = 8'h8a;
  localparam logic [7:0] IDX_TIMER1CNT = 8'h8b;
  localparam logic [7:0] IDX_TIMER2CNT = 8'hcc;
  localparam logic [7:0] IDX_IRQSTAT = 8'h90;
  localparam logic [7:0] IDX_IRQMASK = 8'h91;
  localparam logic [7:0] IDX_POWER = 8'h92;
  // timer01_control: run and carry flag of timer n at RUN0/FLAG0 + n*STRIDE
  localparam int T01_RUN0 = 4;
  localparam int T01_FLAG0 = 5;
  localparam int T01_STRIDE = 2;
  localparam int MODE_HALF_W = 4;
  // counter field layout
  localparam int LOW5_MSB = 4;
  localparam int LOW_MSB = 7;
  localparam int HIGH_LSB = 8;
  localparam int HIGH_MSB = 15;
  // interrupt status and mask bits
  localparam int IRQ_TIMER0 = 0;
  localparam int IRQ_TIMER1 = 1;
  localparam int IRQ_T2CARRY = 2;
  localparam int IRQ_T2EVENT = 3;
  localparam int IRQ_W = 4;
  // power register bits
  localparam int PWR_SOFT = 0;
  localparam int PWR_HARD = 1;
  localparam int PWR_W = 2;
  // reset values
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic PIN_IDLE = 1'b1;
  // response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timer 0/1 operating modes
  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_RELOAD8 = 2'h2,
    MODE_SPLIT = 2'h3
  } tmrMode_t;
  // one half of timer01_mode
  typedef struct packed {
    logic gate;
    logic extClock;
    tmrMode_t mode;
  } tmrModeHalf_t;
  // timer2_control fields, msb first
  typedef struct packed {
    logic carryFlag;
    logic eventFlag;
    logic rxClockSel;
    logic txClockSel;
    logic triggerEnable;
    logic run;
    logic clockSource;
    logic captureReloadSel;
  } timer2Control_t;
  // external pins of the unit
  typedef struct packed {
    logic extIrq1;
    logic extIrq0;
    logic timer2Trigger;
    logic timer2Count;
    logic timer1Count;
    logic timer0Count;
  } pins_t;
  localparam int PIN_W = 6;
  localparam int PIN_TIMER2CNT = 2;
  localparam int PIN_TRIGGER = 3;
  localparam int PIN_IRQ0 = 4;
endpackage

//--- pin_synchronizer.sv
// three-stage pin synchroniser with agreement filter and fall detect
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // asynchronous pin
  input wire logic pinAsync,
  // filtered level and one-cycle high-to-low pulse
  output logic level,
  output logic fall
);
  logic meta_q;
  logic sync2_q;
  logic sync3_q;
  logic level_q;

  // the first stage feeds only the second
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= timer_unit_pkg::PIN_IDLE;
      sync2_q <= timer_unit_pkg::PIN_IDLE;
      sync3_q <= timer_unit_pkg::PIN_IDLE;
    end
    else
    begin
      meta_q <= pinAsync;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      level_q <= timer_unit_pkg::PIN_IDLE;
    else if (sync2_q == sync3_q)
      level_q <= sync3_q;
  end

  assign level = level_q;
  assign fall = level_q & (sync2_q == sync3_q) & ~sync3_q;
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench of the triple timer/counter unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, cpuWake, oscillatorStopped, serialTxBaudTick, serialRxBaudTick;
  logic woke = 1'b0;
  logic [31:0] rdVal;
  timer_unit_pkg::pins_t pins = 6'h3f;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int txCount = 0;
  int rxCount = 0;

  triple_timer_counter_unit dut (.clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pins, .irq, .cpuWake, .oscillatorStopped, .serialTxBaudTick,
    .serialRxBaudTick);

  // 125 MHz clock
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  // wake pulse lasts one cycle, so latch it
  always @(posedge clk_sys) if (cpuWake === 1'b1) woke <= 1'b1;

  // baud ticks also last one cycle; counted so extra ticks show up
  always @(posedge clk_sys)
  begin
    if (serialTxBaudTick === 1'b1) txCount <= txCount + 1;
    if (serialRxBaudTick === 1'b1) rxCount <= rxCount + 1;
  end

  // hang guard, well above the roughly 1000 cycles the tests need
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ready is looked at mid-cycle so the handshake edge is known in advance
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd))
    begin
      @(negedge clk_sys);
      ad |= s_axi_awready;
      dd |= s_axi_wready;
      @(posedge clk_sys);
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !dd;
    end
    do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rdVal = s_axi_rdata;
    rdResp = s_axi_rresp;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `CHK($sformatf("rd %h", a), e, rdVal)
  endtask

  // falling then rising edge, each level held past the pin filter
  task automatic pulse(input int b);
    pins[b] <= 1'b0;
    repeat (8) @(posedge clk_sys);
    pins[b] <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(12'h220, 32'h0);
    rdc(12'h224, 32'h0);
    rdc(12'h320, 32'h0);
    rdc(12'h004, 32'h0);
    `CHK("rresp", 2'h2, rdResp)
    wr(12'h330, 32'h1234);
    repeat (40) @(posedge clk_sys);
    rdc(12'h330, 32'h1234);
    wr(12'h330, 32'hfff0);
    wr(12'h244, 32'h4);
    wr(12'h320, 32'h04);
    repeat (300) @(posedge clk_sys);
    rdc(12'h320, 32'h84);
    `CHK("irq", 1'b1, irq)
    wr(12'h320, 32'h80);
    rdc(12'h240, 32'h4);
    wr(12'h240, 32'h4);
    `CHK("irq", 1'b0, irq)
    rdc(12'h320, 32'h80);
    wr(12'h320, 32'h0);
    wr(12'h248, 32'h1);
    `CHK("osc", 1'b1, oscillatorStopped)
    wr(12'h330, 32'h10);
    wr(12'h320, 32'h04);
    repeat (100) @(posedge clk_sys);
    rdc(12'h330, 32'h10);
    wr(12'h320, 32'h0);
    wr(12'h248, 32'h0);
    `CHK("osc", 1'b0, oscillatorStopped)
    pulse(timer_unit_pkg::PIN_TRIGGER);
    rdc(12'h320, 32'h0);
    wr(12'h320, 32'h08);
    pulse(timer_unit_pkg::PIN_TRIGGER);
    rdc(12'h320, 32'h48);
    wr(12'h320, 32'h0);
    rdc(12'h320, 32'h0);
    // pin-clocked timer 2 counts pin falls only
    wr(12'h330, 32'h0);
    wr(12'h320, 32'h06);
    pulse(timer_unit_pkg::PIN_TIMER2CNT);
    pulse(timer_unit_pkg::PIN_TIMER2CNT);
    rdc(12'h330, 32'h2);
    // baud use: one overflow feeds the tx tick, carry flag stays clear
    wr(12'h330, 32'hfff0);
    wr(12'h320, 32'h14);
    repeat (100) @(posedge clk_sys);
    rdc(12'h320, 32'h14);
    `CHK("tx ticks", 1, txCount)
    `CHK("rx ticks", 0, rxCount)
    wr(12'h320, 32'h0);
    // timer 0 in 13-bit mode and timer 1 in 8-bit reload, both on pin edges
    wr(12'h228, 32'h011f);
    wr(12'h22c, 32'h05fe);
    wr(12'h224, 32'h64);
    wr(12'h220, 32'h50);
    pulse(0);
    pulse(1);
    pulse(1);
    rdc(12'h228, 32'h0200);
    rdc(12'h22c, 32'h0505);
    rdc(12'h220, 32'hd0);
    `CHK("tx ticks", 2, txCount)
    `CHK("rx ticks", 1, rxCount)
    wr(12'h220, 32'h0);
    wr(12'h228, 32'h0);
    wr(12'h224, 32'h09);
    // let the gate pin settle before the run bit lands
    pins.extIrq0 <= 1'b0;
    repeat (8) @(posedge clk_sys);
    wr(12'h220, 32'h10);
    repeat (100) @(posedge clk_sys);
    rdc(12'h228, 32'h0);
    pins.extIrq0 <= 1'b1;
    repeat (100) @(posedge clk_sys);
    rd(12'h228);
    `CHK("t0 counts", 1'b1, rdVal != 32'h0)
    wr(12'h220, 32'h0);
    wr(12'h224, 32'h05);
    wr(12'h228, 32'hffff);
    wr(12'h220, 32'h10);
    wr(12'h248, 32'h1);
    pulse(0);
    `CHK("wake", 1'b1, woke)
    rdc(12'h248, 32'h0);
    rdc(12'h228, 32'h0);
    rdc(12'h220, 32'h30);
    wrap_up();
  end
endmodule
`default_nettype wire
